// ===== hw/wrcu_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "wrcu_map.svh"
// Notes on behaviour
// - instruction: opcode, register select, two zero bits
// - decode seven opcodes, select for setting ops
// - transfers end after instruction acknowledge
// - setting to wiper loads after response delay
// - wiper to setting is a nonvolatile write
// - reads and writes carry a third data byte
// - step with sda high moves wiper up
// - step with sda low moves down, until stop
// - six-bit wiper decoded to one of 64 taps
// - power-up loads wiper from setting zero
// - setting writes finish within ten milliseconds
// - four six-bit nonvolatile setting registers
// - wiper loaded directly, from or into settings
// - don't-care instruction bits are ignored
// - acknowledge only a full address match
// - no address acknowledge while writing nonvolatile
// - write protect low blocks setting writes
module wrcu_device #(
  parameter int NV_CYCLES = `WRCU_NV_WRITE_US * `WRCU_CLK_MHZ
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // serial bus
  wrcu_if.dev bus,
  // straps: {addr bit3, addr bit2, strap_addr_bit0}
  input wire logic [2:0] i_strap_addr,
  input wire logic i_write_protect_n,
  // wiper and status
  output wrcu_pkg::wrcu_pos_t o_wiper_position,
  output logic [63:0] o_wiper_tap,
  output logic o_nv_busy
);
  import wrcu_pkg::*;

  localparam int WRL_CYCLES = (`WRCU_WRL_NS + `WRCU_CLK_PERIOD_NS - 1) / `WRCU_CLK_PERIOD_NS;

  generate
    if (NV_CYCLES < 1 || NV_CYCLES >= 2 ** 20 || NV_CYCLES > 10000 * `WRCU_CLK_MHZ ||
        WRL_CYCLES < 1 || WRL_CYCLES >= 4096) begin : g_chk_counts
      $error("timing counts out of range");
    end
  endgenerate

  // saturating one-step move of the wiper
  function automatic wrcu_pos_t step_pos(input wrcu_pos_t pos, input logic up);
    wrcu_pos_t res;
    res = pos;
    if (up && pos != 6'h3f) res = pos + 6'h01;
    if (!up && pos != 6'h00) res = pos - 6'h01;
    return res;
  endfunction : step_pos

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers: the first stage feeds only the second
  logic scl_m, sda_m, wp_m, scl_s, sda_s, wp_s, scl_d, sda_d;
  logic [2:0] strap_m, strap_s;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {scl_m, sda_m, wp_m, strap_m} <= 6'h3f;
      {scl_s, sda_s, wp_s, strap_s} <= 6'h3f;
      {scl_d, sda_d} <= 2'h3;
    end else begin
      {scl_m, sda_m, wp_m, strap_m} <= {bus.scl, bus.sda, i_write_protect_n, i_strap_addr};
      {scl_s, sda_s, wp_s, strap_s} <= {scl_m, sda_m, wp_m, strap_m};
      {scl_d, sda_d} <= {scl_s, sda_s};
    end
  end

  // bus events from the synchronised lines
  logic start_ev, stop_ev, scl_rise, scl_fall;
  assign start_ev = scl_s && scl_d && sda_d && !sda_s;
  assign stop_ev = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;

  //////////////////////////////////////////////////////////////////////////////
  // state
  wrcu_dev_state_e st, next_st, after, next_after;
  logic [3:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg, outbyte, next_out;
  logic sda_oe, next_oe;
  logic [3:0] op, next_op;
  logic [1:0] sel, next_sel, pend_idx, next_pidx;
  wrcu_pos_t wiper, next_wiper, pend_val, next_pval, wrl_val, next_wrlval;
  logic pend_nv, next_pend, nv_busy, next_busy, wrl_pend, next_wrlpend, pu, next_pu;
  logic [19:0] nv_cnt, next_nvcnt;
  logic [11:0] wrl_cnt, next_wrlcnt;
  logic [63:0] tap;
  // nonvolatile content survives i_rst, so it has no reset term
  wrcu_pos_t setting [4] = '{default: `WRCU_SETTING_INIT};
  wrcu_pos_t next_setting [4];

  // next-state logic
  always_comb begin
    next_st = st;
    next_after = after;
    next_bitn = bitn;
    next_shreg = shreg;
    next_out = outbyte;
    next_oe = sda_oe;
    next_op = op;
    next_sel = sel;
    next_wiper = wiper;
    next_pend = pend_nv;
    next_pidx = pend_idx;
    next_pval = pend_val;
    next_busy = nv_busy;
    next_nvcnt = nv_cnt;
    next_wrlpend = wrl_pend;
    next_wrlval = wrl_val;
    next_wrlcnt = wrl_cnt;
    next_pu = 1'b0;
    next_setting = setting;
    if (pu) next_wiper = setting[0];
    // nonvolatile write timer, value lands at the end of the cycle
    if (nv_busy) begin
      next_nvcnt = nv_cnt - 20'h00001;
      if (nv_cnt == 20'h00001) begin
        next_busy = 1'b0;
        next_pend = 1'b0;
        next_setting[pend_idx] = pend_val;
      end
    end
    // wiper follows a transfer only after the response delay
    if (wrl_pend) begin
      next_wrlcnt = wrl_cnt - 12'h001;
      if (wrl_cnt == 12'h001) begin
        next_wrlpend = 1'b0;
        next_wiper = wrl_val;
      end
    end
    if (start_ev) begin
      next_st = DS_ADDR;
      next_bitn = 4'h0;
      next_oe = 1'b0;
    end else if (stop_ev) begin
      next_st = DS_IDLE;
      next_oe = 1'b0;
      // the internal write starts only once the frame is closed
      if (pend_nv && !nv_busy) begin
        next_busy = 1'b1;
        next_nvcnt = NV_CYCLES[19:0];
      end
    end else if (st == DS_STEP) begin
      if (scl_fall) next_wiper = step_pos(wiper, sda_s); // stop's high is no step
    end else if (st != DS_IDLE) begin
      if (scl_rise) begin
        if (bitn < 4'h8) next_shreg = {shreg[6:0], sda_s};
        next_bitn = bitn + 4'h1;
      end else if (scl_fall) begin
        if (bitn == 4'h8) begin
          next_oe = 1'b1;
          next_after = DS_DONE;
          case (st)
            DS_ADDR: begin
              if (shreg[7:4] == `WRCU_TYPE_ID &&
                  shreg[3:0] == {strap_s[2:1], 1'b0, strap_s[0]} && !nv_busy) begin
                next_after = DS_INSTR;
              end else begin
                next_oe = 1'b0;
                next_st = DS_IDLE;
              end
            end
            DS_INSTR: begin
              next_op = shreg[7:4];
              next_sel = shreg[3:2];
              case (shreg[7:4])
                `WRCU_OP_RD_WIPER, `WRCU_OP_RD_SET: begin
                  next_after = DS_OUT;
                  next_out = {2'b00, (shreg[5] ? setting[shreg[3:2]] : wiper)};
                end
                `WRCU_OP_WR_WIPER, `WRCU_OP_WR_SET: next_after = DS_IN;
                `WRCU_OP_SET2WIP: begin
                  next_wrlpend = 1'b1;
                  next_wrlval = setting[shreg[3:2]];
                  next_wrlcnt = WRL_CYCLES[11:0];
                end
                `WRCU_OP_WIP2SET: begin
                  next_pend = wp_s;
                  next_pidx = shreg[3:2];
                  next_pval = wiper;
                end
                `WRCU_OP_STEP: next_after = DS_STEP;
                default: begin
                  next_oe = 1'b0;
                  next_st = DS_IDLE;
                end
              endcase
            end
            DS_IN: begin
              if (op == `WRCU_OP_WR_WIPER) next_wiper = shreg[5:0];
              else begin
                next_pend = wp_s;
                next_pidx = sel;
                next_pval = shreg[5:0];
              end
            end
            default: next_oe = 1'b0; // master acknowledge slot or extra bytes
          endcase
        end else if (bitn == 4'h9) begin
          next_bitn = 4'h0;
          next_st = after;
          next_oe = (after == DS_OUT) ? ~outbyte[7] : 1'b0;
        end else if (st == DS_OUT) begin
          next_oe = ~outbyte[3'd7 - bitn[2:0]];
        end
      end
    end
  end

  // registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= DS_IDLE;
      after <= DS_DONE;
      bitn <= 4'h0;
      shreg <= 8'h00;
      outbyte <= 8'h00;
      sda_oe <= 1'b0;
      op <= 4'h0;
      sel <= 2'h0;
      wiper <= `WRCU_WIPER_RST;
      tap <= 64'h1;
      pend_nv <= 1'b0;
      pend_idx <= 2'h0;
      pend_val <= 6'h00;
      nv_busy <= 1'b0;
      nv_cnt <= 20'h00000;
      wrl_pend <= 1'b0;
      wrl_val <= 6'h00;
      wrl_cnt <= 12'h000;
      pu <= 1'b1;
    end else begin
      st <= next_st;
      after <= next_after;
      bitn <= next_bitn;
      shreg <= next_shreg;
      outbyte <= next_out;
      sda_oe <= next_oe;
      op <= next_op;
      sel <= next_sel;
      wiper <= next_wiper;
      tap <= 64'h1 << next_wiper; // one-hot tap decode
      pend_nv <= next_pend;
      pend_idx <= next_pidx;
      pend_val <= next_pval;
      nv_busy <= next_busy;
      nv_cnt <= next_nvcnt;
      wrl_pend <= next_wrlpend;
      wrl_val <= next_wrlval;
      wrl_cnt <= next_wrlcnt;
      pu <= next_pu;
    end
  end

  // setting store, no reset
  always_ff @(posedge i_clk) begin
    setting <= next_setting;
  end

  assign bus.dev_sda_oe = sda_oe;
  assign o_wiper_position = wiper;
  assign o_wiper_tap = tap;
  assign o_nv_busy = nv_busy;
endmodule : wrcu_device
`default_nettype wire

// ===== hw/wrcu_map.svh
`ifndef WRCU_MAP_SVH
`define WRCU_MAP_SVH
// clock and timing
`define WRCU_CLK_PERIOD_NS 10
`define WRCU_CLK_MHZ 100
`define WRCU_WRL_NS 1000
`define WRCU_NV_WRITE_US 5000
`define WRCU_SCL_QTR_CYC 10
// device type nibble, value is arbitrary
`define WRCU_TYPE_ID 4'ha
// instruction opcodes
`define WRCU_OP_RD_WIPER 4'h9
`define WRCU_OP_WR_WIPER 4'ha
`define WRCU_OP_RD_SET 4'hb
`define WRCU_OP_WR_SET 4'hc
`define WRCU_OP_SET2WIP 4'hd
`define WRCU_OP_WIP2SET 4'he
`define WRCU_OP_STEP 4'h2
// controller register offsets
`define WRCU_CMD_OFS 12'h000
`define WRCU_STATUS_OFS 12'h004
// command fields
`define WRCU_CMD_DATA_LSB 8
`define WRCU_CMD_ADDR_LSB 16
`define WRCU_CMD_STEPS_LSB 20
`define WRCU_CMD_DIR_BIT 28
// status fields
`define WRCU_ST_BUSY_BIT 0
`define WRCU_ST_NACK_BIT 1
`define WRCU_ST_RDATA_LSB 8
// reset values
`define WRCU_WIPER_RST 6'h00
`define WRCU_SETTING_INIT 6'h00
`endif

// ===== hw/wrcu_pkg.sv
`default_nettype none
package wrcu_pkg;
  typedef logic [5:0] wrcu_pos_t;
  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_INSTR, DS_IN, DS_OUT, DS_STEP, DS_DONE
  } wrcu_dev_state_e;
  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_SEND, HS_RECV, HS_STEP, HS_STOP
  } wrcu_host_state_e;
endpackage : wrcu_pkg
`default_nettype wire

// ===== hw/wrcu_if.sv
`timescale 1ns/10ps
`default_nettype none
interface wrcu_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sda;
  // open drain: any enable pulls the line low, otherwise the pull-up wins
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host (output scl, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_oe);
endinterface : wrcu_if
`default_nettype wire

// ===== hw/wrcu_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "wrcu_map.svh"
module wrcu_host #(
  parameter int QTR = `WRCU_SCL_QTR_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // serial bus
  wrcu_if.host bus
);
  import wrcu_pkg::*;

  generate
    if (QTR < 4 || QTR > 255) begin : g_chk_qtr
      $error("quarter bit count out of range");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // sda synchroniser and quarter-bit divider
  logic sda_m, sda_s;
  logic [7:0] div;
  logic tick;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      div <= 8'h00;
    end else begin
      sda_m <= bus.sda;
      sda_s <= sda_m;
      div <= tick ? 8'h00 : div + 8'h01;
    end
  end
  assign tick = (div == QTR[7:0] - 8'h01);

  //////////////////////////////////////////////////////////////////////////////
  wrcu_host_state_e st, next_st;
  logic [1:0] q, next_q, byten, next_byten;
  logic [3:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg, steps, next_steps;
  logic [31:0] cmd, next_cmd, prdata, next_prdata;
  logic scl, next_scl, oe, next_oe, busy, next_busy, nack, next_nack;
  logic pready, next_pready, slverr, next_slverr, cmd_wr;
  wrcu_pos_t rdata, next_rdata;
  logic [3:0] opc;
  assign opc = cmd[7:4];

  // apb decode plus bit engine; q walks four quarters of each scl bit
  always_comb begin
    next_pready = 1'b0;
    next_slverr = 1'b0;
    next_prdata = prdata;
    cmd_wr = 1'b0;
    next_st = st;
    next_q = q;
    next_byten = byten;
    next_bitn = bitn;
    next_shreg = shreg;
    next_steps = steps;
    next_cmd = cmd;
    next_scl = scl;
    next_oe = oe;
    next_busy = busy;
    next_nack = nack;
    next_rdata = rdata;
    // one wait state, answer registered
    if (i_psel && i_penable && !pready) begin
      next_pready = 1'b1;
      case (i_paddr)
        `WRCU_CMD_OFS: begin
          cmd_wr = i_pwrite;
          next_prdata = cmd;
        end
        `WRCU_STATUS_OFS: begin
          next_prdata = 32'h0;
          next_prdata[`WRCU_ST_BUSY_BIT] = busy;
          next_prdata[`WRCU_ST_NACK_BIT] = nack;
          next_prdata[`WRCU_ST_RDATA_LSB +: 6] = rdata;
        end
        default: begin
          next_slverr = 1'b1;
          next_prdata = 32'h0;
        end
      endcase
    end
    if (cmd_wr && !busy) begin
      next_cmd = i_pwdata; // low two instruction bits go out as software wrote them
      next_busy = 1'b1;
      next_nack = 1'b0;
      next_st = HS_START;
      next_q = 2'h0;
    end else if (tick && st != HS_IDLE) begin
      next_q = q + 2'h1;
      case (st)
        HS_START: begin
          if (q == 2'h1) next_oe = 1'b1;
          if (q == 2'h2) next_scl = 1'b0;
          if (q == 2'h3) begin
            next_st = HS_SEND;
            next_byten = 2'h0;
            next_bitn = 4'h0;
            // type nibble, then {a3, a2, 0, a0}
            next_shreg = {`WRCU_TYPE_ID, cmd[`WRCU_CMD_ADDR_LSB + 1 +: 2], 1'b0,
                          cmd[`WRCU_CMD_ADDR_LSB]};
          end
        end
        HS_SEND: begin
          if (q == 2'h0) next_oe = (bitn < 4'h8) ? ~shreg[7] : 1'b0;
          if (q == 2'h1) next_scl = 1'b1;
          if (q == 2'h2 && bitn == 4'h8) next_nack = sda_s;
          if (q == 2'h3) begin
            next_scl = 1'b0;
            next_bitn = bitn + 4'h1;
            next_shreg = {shreg[6:0], 1'b0};
            if (bitn == 4'h8) begin
              next_bitn = 4'h0;
              next_byten = byten + 2'h1;
              next_st = HS_STOP;
              if (!nack && byten == 2'h0) begin
                next_st = HS_SEND;
                next_shreg = cmd[7:0];
              end else if (!nack && byten == 2'h1) begin
                case (opc) // transfers fall through to stop
                  `WRCU_OP_WR_WIPER, `WRCU_OP_WR_SET: begin
                    next_st = HS_SEND;
                    next_shreg = {2'b00, cmd[`WRCU_CMD_DATA_LSB +: 6]};
                  end
                  `WRCU_OP_RD_WIPER, `WRCU_OP_RD_SET: next_st = HS_RECV;
                  `WRCU_OP_STEP: begin
                    next_steps = cmd[`WRCU_CMD_STEPS_LSB +: 8];
                    if (cmd[`WRCU_CMD_STEPS_LSB +: 8] != 8'h00) next_st = HS_STEP;
                  end
                  default: next_st = HS_STOP;
                endcase
              end
            end
          end
        end
        HS_RECV: begin
          if (q == 2'h0) next_oe = (bitn == 4'h8); // master_acknowledge
          if (q == 2'h1) next_scl = 1'b1;
          if (q == 2'h2 && bitn < 4'h8) next_shreg = {shreg[6:0], sda_s};
          if (q == 2'h3) begin
            next_scl = 1'b0;
            next_bitn = bitn + 4'h1;
            if (bitn == 4'h8) begin
              next_rdata = shreg[5:0];
              next_st = HS_STOP;
            end
          end
        end
        HS_STEP: begin
          if (q == 2'h0) next_oe = ~cmd[`WRCU_CMD_DIR_BIT];
          if (q == 2'h1) next_scl = 1'b1;
          if (q == 2'h3) begin
            next_scl = 1'b0;
            next_steps = steps - 8'h01;
            if (steps == 8'h01) next_st = HS_STOP;
          end
        end
        HS_STOP: begin
          if (q == 2'h0) next_oe = 1'b1;
          if (q == 2'h1) next_scl = 1'b1;
          if (q == 2'h2) next_oe = 1'b0;
          if (q == 2'h3) begin
            next_st = HS_IDLE;
            next_busy = 1'b0;
          end
        end
        default: next_st = HS_IDLE;
      endcase
    end
  end

  // registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= HS_IDLE;
      q <= 2'h0;
      byten <= 2'h0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      steps <= 8'h00;
      cmd <= 32'h0;
      scl <= 1'b1;
      oe <= 1'b0;
      busy <= 1'b0;
      nack <= 1'b0;
      rdata <= 6'h00;
      pready <= 1'b0;
      slverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      st <= next_st;
      q <= next_q;
      byten <= next_byten;
      bitn <= next_bitn;
      shreg <= next_shreg;
      steps <= next_steps;
      cmd <= next_cmd;
      scl <= next_scl;
      oe <= next_oe;
      busy <= next_busy;
      nack <= next_nack;
      rdata <= next_rdata;
      pready <= next_pready;
      slverr <= next_slverr;
      prdata <= next_prdata;
    end
  end

  assign bus.scl = scl;
  assign bus.host_sda_oe = oe;
  assign o_prdata = prdata;
  assign o_pready = pready;
  assign o_pslverr = slverr;
endmodule : wrcu_host
`default_nettype wire

// ===== dv/wrcu_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module wrcu_assertions #(
  parameter int NV = 200,
  parameter int QTR = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // serial link
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda,
  // device outputs
  input wire wrcu_pkg::wrcu_pos_t o_wiper_position,
  input wire logic [63:0] o_wiper_tap,
  input wire logic o_nv_busy
);
  import wrcu_pkg::*;
  int unsigned nv_cnt;
  int unsigned oe_cnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // run lengths; ack plus eight zero bits is the longest legal pull
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      nv_cnt <= 0;
      oe_cnt <= 0;
    end else begin
      nv_cnt <= o_nv_busy ? nv_cnt + 1 : 0;
      oe_cnt <= dev_sda_oe ? oe_cnt + 1 : 0;
    end
  end
  ////////////////////////////////////////
  property p_tap;
    o_wiper_tap == (64'h1 << o_wiper_position);
  endproperty
  a_tap: assert property (p_tap) else $error("tap not one-hot of wiper");
  property p_dev_chg;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_dev_chg: assert property (p_dev_chg) else $error("device sda moved in scl high");
  property p_dev_run;
    oe_cnt <= 36 * QTR + 8;
  endproperty
  a_dev_run: assert property (p_dev_run) else $error("device holds sda too long");
  // one cycle of slack either way on the write length
  property p_nv_len;
    $fell(o_nv_busy) |-> nv_cnt + 1 >= NV && nv_cnt <= NV + 1;
  endproperty
  a_nv_len: assert property (p_nv_len) else $error("nv write length wrong");
  property p_busy_quiet;
    o_nv_busy |-> !dev_sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("device answered while busy");
  property p_busy_hold;
    o_nv_busy && $past(o_nv_busy) |-> $stable(o_wiper_position);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("wiper moved during nv write");
  property p_busy_stop;
    $rose(o_nv_busy) |-> scl && sda;
  endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("nv write began before stop");
  property p_idle;
    $past(i_rst) |-> scl && !host_sda_oe && !dev_sda_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("bus not idle after reset");
  c_nv: cover property ($rose(o_nv_busy));
  c_top: cover property (o_wiper_position == 6'h3f && scl);
  c_dev: cover property ($rose(dev_sda_oe));
endmodule : wrcu_assertions
`default_nettype wire

// ===== dv/wiper_register_command_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module wiper_register_command_unit_tb;
  import wrcu_pkg::*;
  // short nv write and quarter bit keep the run small
  localparam int NV = 200;
  localparam int QTR = 4;
  localparam logic [2:0] SA = 3'b101;
  logic clk, rst, psel, pen, pwr, wp_n, pready, pslverr, e, nv_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, st;
  logic [63:0] tap;
  logic [1:0] rr;
  wrcu_pos_t wiper, v;
  int n_mismatch, checked;
  wrcu_if u_bus ();
  wrcu_device #(.NV_CYCLES(NV)) u_wrcu_device (.i_clk(clk), .i_rst(rst), .bus(u_bus),
    .i_strap_addr(SA), .i_write_protect_n(wp_n), .o_wiper_position(wiper),
    .o_wiper_tap(tap), .o_nv_busy(nv_busy));
  wrcu_host #(.QTR(QTR)) u_wrcu_host (.i_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .bus(u_bus));
  wrcu_assertions #(.NV(NV), .QTR(QTR)) u_wrcu_assertions (.i_clk(clk), .i_rst(rst),
    .scl(u_bus.scl), .host_sda_oe(u_bus.host_sda_oe), .dev_sda_oe(u_bus.dev_sda_oe),
    .sda(u_bus.sda), .o_wiper_position(wiper), .o_wiper_tap(tap), .o_nv_busy(nv_busy));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic tally(input logic ok, input logic [63:0] a, x);
    checked++;
    if (!ok) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, a, x);
    end
  endtask : tally
  task automatic chk_pos(input wrcu_pos_t a, x);
    tally(a === x, 64'(a), 64'(x));
  endtask : chk_pos
  task automatic chk_bit(input logic a, x);
    tally(a === x, 64'(a), 64'(x));
  endtask : chk_bit
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // issue one frame, then poll status until the host is idle
  task automatic cmd(input logic [7:0] ins, input wrcu_pos_t d = 6'h00,
                     input logic [7:0] ns = 8'h00, input logic up = 1'b0,
                     input logic [2:0] ad = SA);
    int n;
    n = 0;
    apb(1'b1, 12'h000, {3'h0, up, ns, 1'b0, ad, 2'h0, d, ins}, q, e);
    do begin
      apb(1'b0, 12'h004, 32'h0, st, e);
      n++;
    end while (st[0] !== 1'b0 && n < 500);
    if (n >= 500) n_mismatch++;
    @(negedge clk);
  endtask : cmd
  // nv write starts a few cycles after stop is seen
  task automatic nvw;
    int n;
    n = 0;
    repeat (5) @(posedge clk);
    while (nv_busy !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) n_mismatch++;
  endtask : nvw
  initial begin
    #900000;
    n_mismatch++;
    end_sim();
  end
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, paddr, pwdata} = '0;
    wp_n = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(negedge clk);
    chk_pos(wiper, 6'h00);
    tally(tap === 64'h1, tap, 64'h1);
    apb(1'b0, 12'h008, 32'h0, q, e);
    chk_bit(e, 1'b1);
    // every setting register, junk in the low instruction bits on read
    for (int r = 0; r < 4; r++) begin
      rr = 2'(r);
      v = 6'h3f - 6'(r * 21);
      cmd({4'hc, rr, 2'b00}, v);
      nvw();
      cmd({4'hb, rr, 2'b11});
      chk_pos(st[13:8], v);
    end
    cmd(8'ha0, 6'h3d);
    chk_pos(wiper, 6'h3d);
    tally(tap === 64'h1 << 61, tap, 64'h1 << 61);
    cmd(8'h90);
    chk_pos(st[13:8], 6'h3d);
    cmd(8'h20, 6'h00, 8'h01, 1'b1);
    chk_pos(wiper, 6'h3e);
    cmd(8'h20, 6'h00, 8'h05, 1'b1);
    chk_pos(wiper, 6'h3f);
    cmd(8'h20, 6'h00, 8'h03);
    chk_pos(wiper, 6'h3c);
    cmd(8'ha0, 6'h01);
    cmd(8'h20, 6'h00, 8'h04);
    chk_pos(wiper, 6'h00);
    cmd(8'hd8);
    chk_pos(wiper, 6'h00);
    repeat (120) @(negedge clk);
    chk_pos(wiper, 6'h15);
    cmd(8'hec);
    chk_bit(nv_busy, 1'b1);
    cmd(8'h90);
    chk_bit(st[1], 1'b1);
    nvw();
    cmd(8'hbc);
    chk_pos(st[13:8], 6'h15);
    cmd(8'h90, 6'h00, 8'h00, 1'b0, 3'b100);
    chk_bit(st[1], 1'b1);
    cmd(8'h50);
    chk_bit(st[1], 1'b1);
    @(posedge clk) wp_n <= 1'b0;
    cmd(8'hc4, 6'h07);
    nvw();
    @(posedge clk) wp_n <= 1'b1;
    cmd(8'hb4);
    chk_pos(st[13:8], 6'h2a);
    // second power-up recalls setting zero
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    chk_pos(wiper, 6'h3f);
    end_sim();
  end
endmodule : wiper_register_command_unit_tb
`default_nettype wire
